// ===== slc_consts.svh
// Offsets, field positions, reset values and timing figures
// Assumes a 40 MHz core clock and a byte-addressed APB
`ifndef SLC_CONSTS_SVH
`define SLC_CONSTS_SVH
`define SLC_OFS_STATUS 8'h00
`define SLC_OFS_CTRL 8'h04
`define SLC_OFS_CFG 8'h08
`define SLC_CTRL_HOLD_BIT 0
`define SLC_CTRL_RST 1'b0
`define SLC_CLK_KHZ 40000
`define SLC_RST_MIN_MS 250
`define SLC_RST_MAX_MS 2000
`define SLC_RST_MIN_CYC (`SLC_RST_MIN_MS * `SLC_CLK_KHZ)
`define SLC_RST_MAX_CYC (`SLC_RST_MAX_MS * `SLC_CLK_KHZ)
`define SLC_ERR_NONE 8'h00
`define SLC_ERR_BANK 8'h01
`define SLC_ERR_TRIPLATCH 8'h02
`define SLC_ERR_CFGCHG 8'h03
`endif

// ===== slc_pkg.sv
// Types shared by the curtain control block
// Assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package slc_pkg;
   typedef enum logic [2:0] {ST_POWERUP, ST_SYNC, ST_OFF, ST_ON, ST_LOCK} slc_main_t;
   typedef enum logic [1:0] {RD_WAIT_OPEN, RD_OPEN, RD_CLOSED} slc_rdet_t;
   typedef struct packed {
      logic scan_code_second;
      logic latch_a;
      logic latch_b;
      logic coarse_a;
      logic coarse_b;
      logic single_channel_monitor_setting;
   } slc_cfg_t;
   typedef struct packed {
      slc_main_t main;
      slc_rdet_t rd;
      logic [26:0] cnt;
      logic rst_ok;
      slc_cfg_t snap;
      logic [7:0] err;
      logic hold;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic [1:0] safety_output_pair;
      logic aux;
      logic lock;
      logic mon_err;
      logic blank_ok;
      logic coarse_en;
      logic scan;
   } slc_state_t;
endpackage
`default_nettype wire

// ===== slc_curtain_ctrl.sv
// Receiver control: configuration check, monitored reset, lockout, safety outputs
// Assumes inputs synchronous to CORE_CLK; RST is the power-up reset
`default_nettype none
`include "slc_consts.svh"
module slc_curtain_ctrl
   import slc_pkg::*;
#(
   parameter int unsigned RST_MIN_CYC = `SLC_RST_MIN_CYC,
   parameter int unsigned RST_MAX_CYC = `SLC_RST_MAX_CYC
)
(
   // Clock and power-up reset
   input wire logic CORE_CLK,
   input wire logic RST,
   // APB slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic PREADY,
   output logic [31:0] PRDATA,
   output logic PSLVERR,
   // Switches and operator reset
   input wire slc_cfg_t CFG_SW,
   input wire logic RESET_IN,
   // Scanner status and machine monitor contacts
   input wire logic SELF_TEST_OK,
   input wire logic BEAMS_CLEAR,
   input wire logic EMITTER_SCAN_CODE,
   input wire logic [1:0] EXTERNAL_DEVICE_MONITOR,
   // Machine side and indication
   output logic [1:0] SAFETY_OUTPUT_PAIR,
   output logic AUX_OUT,
   output logic LOCKOUT,
   output logic [7:0] ERROR_CODE,
   output logic MONITOR_ERROR,
   output logic BLANKING_ALLOWED,
   output logic COARSE_DETECTION_EN,
   output logic SCAN_CODE_SECOND
);
   localparam logic [26:0] MIN_C = 27'(RST_MIN_CYC);
   localparam logic [26:0] MAX_C = 27'(RST_MAX_CYC);

   slc_state_t s_reg;
   slc_state_t s_next;
   logic pair_bad;
   logic chg;
   logic fault;
   logic latch;
   logic single;
   logic mon_ok;
   logic go_ok;

   function automatic logic [4:0] fixed_cfg(input slc_cfg_t c);
      fixed_cfg = {c.latch_a, c.latch_b, c.coarse_a, c.coarse_b,
         c.single_channel_monitor_setting};
   endfunction

   always_comb
   begin
      pair_bad = (CFG_SW.latch_a != CFG_SW.latch_b) || (CFG_SW.coarse_a != CFG_SW.coarse_b);
      // Scan code deliberately left out of the comparison
      chg = fixed_cfg(CFG_SW) != fixed_cfg(s_reg.snap);
      fault = pair_bad || chg;
      latch = s_reg.snap.latch_a;
      single = s_reg.snap.single_channel_monitor_setting;
      // Dual mode also covers the jumpered no-monitoring wiring
      mon_ok = single ? EXTERNAL_DEVICE_MONITOR[0] : (&EXTERNAL_DEVICE_MONITOR);
      go_ok = BEAMS_CLEAR && SELF_TEST_OK && mon_ok && !s_reg.hold &&
         (EMITTER_SCAN_CODE == CFG_SW.scan_code_second);
   end

   always_comb
   begin
      s_next = s_reg;
      s_next.rst_ok = 1'b0;
      // Monitored reset: counter holds closed cycles seen so far
      case (s_reg.rd)
         RD_WAIT_OPEN:
         begin
            if (!RESET_IN)
            begin
               s_next.rd = RD_OPEN;
            end
         end
         RD_OPEN:
         begin
            if (RESET_IN)
            begin
               s_next.rd = RD_CLOSED;
               s_next.cnt = 27'h0000001;
            end
         end
         RD_CLOSED:
         begin
            if (!RESET_IN)
            begin
               s_next.rd = RD_OPEN;
               s_next.rst_ok = (s_reg.cnt >= MIN_C) && (s_reg.cnt <= MAX_C);
            end
            else if (s_reg.cnt > MAX_C)
            begin
               // Held too long: must see open again before arming
               s_next.rd = RD_WAIT_OPEN;
            end
            else
            begin
               s_next.cnt = s_reg.cnt + 27'h0000001;
            end
         end
         default:
         begin
            s_next.rd = RD_WAIT_OPEN;
         end
      endcase

      case (s_reg.main)
         ST_POWERUP:
         begin
            // Snapshot taken after release; a power cycle re-runs this check
            s_next.snap = CFG_SW;
            if (CFG_SW.latch_a != CFG_SW.latch_b)
            begin
               s_next.main = ST_LOCK;
               s_next.err = `SLC_ERR_TRIPLATCH;
            end
            else if (CFG_SW.coarse_a != CFG_SW.coarse_b)
            begin
               s_next.main = ST_LOCK;
               s_next.err = `SLC_ERR_BANK;
            end
            else
            begin
               s_next.main = ST_SYNC;
            end
         end
         ST_SYNC:
         begin
            if (fault)
            begin
               s_next.main = ST_LOCK;
               s_next.err = `SLC_ERR_CFGCHG;
            end
            else if (SELF_TEST_OK)
            begin
               s_next.main = ST_OFF;
            end
         end
         ST_OFF:
         begin
            if (fault)
            begin
               s_next.main = ST_LOCK;
               s_next.err = `SLC_ERR_CFGCHG;
            end
            else if (go_ok && (!latch || s_reg.rst_ok))
            begin
               // Trip needs no reset input at all
               s_next.main = ST_ON;
            end
         end
         ST_ON:
         begin
            if (fault)
            begin
               s_next.main = ST_LOCK;
               s_next.err = `SLC_ERR_CFGCHG;
            end
            else if (!go_ok)
            begin
               s_next.main = ST_OFF;
            end
         end
         ST_LOCK:
         begin
            // A changed switch counts as cycled once it is back
            if (s_reg.rst_ok && !pair_bad && (s_reg.err != `SLC_ERR_CFGCHG || !chg))
            begin
               s_next.main = ST_OFF;
               s_next.err = `SLC_ERR_NONE;
               s_next.snap = CFG_SW;
            end
         end
         default:
         begin
            s_next.main = ST_LOCK;
         end
      endcase

      s_next.safety_output_pair = {2{s_next.main == ST_ON}};
      s_next.aux = single && (s_next.main == ST_ON);
      s_next.lock = s_next.main == ST_LOCK;
      s_next.mon_err = !single && (EXTERNAL_DEVICE_MONITOR[0] != EXTERNAL_DEVICE_MONITOR[1]);
      s_next.blank_ok = !s_next.mon_err;
      s_next.coarse_en = s_next.snap.coarse_a && s_next.snap.coarse_b;
      s_next.scan = CFG_SW.scan_code_second;

      // APB: no wait state, data and error registered in setup
      s_next.pready = 1'b0;
      s_next.pslverr = 1'b0;
      if (PSEL && !PENABLE)
      begin
         s_next.pready = 1'b1;
         s_next.prdata = 32'h00000000;
         case (PADDR)
            `SLC_OFS_STATUS:
            begin
               s_next.prdata = {13'h0000, s_reg.safety_output_pair, s_reg.mon_err, s_reg.lock,
                  s_reg.rd, s_reg.main, 2'h0, s_reg.err};
            end
            `SLC_OFS_CTRL:
            begin
               s_next.prdata = {31'h00000000, s_reg.hold};
            end
            `SLC_OFS_CFG:
            begin
               s_next.prdata = {26'h0000000, s_reg.snap};
            end
            default:
            begin
               s_next.pslverr = 1'b1;
            end
         endcase
      end
      if (PSEL && PENABLE && s_reg.pready && PWRITE && PADDR == `SLC_OFS_CTRL)
      begin
         // Software stop: drops outputs like a blocked beam
         s_next.hold = PWDATA[`SLC_CTRL_HOLD_BIT];
      end
   end

   always_ff @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
      begin
         s_reg <= '0;
         s_reg.main <= ST_POWERUP;
         s_reg.rd <= RD_WAIT_OPEN;
         s_reg.hold <= `SLC_CTRL_RST;
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   assign PREADY = s_reg.pready;
   assign PRDATA = s_reg.prdata;
   assign PSLVERR = s_reg.pslverr;
   assign SAFETY_OUTPUT_PAIR = s_reg.safety_output_pair;
   assign AUX_OUT = s_reg.aux;
   assign LOCKOUT = s_reg.lock;
   assign ERROR_CODE = s_reg.err;
   assign MONITOR_ERROR = s_reg.mon_err;
   assign BLANKING_ALLOWED = s_reg.blank_ok;
   assign COARSE_DETECTION_EN = s_reg.coarse_en;
   assign SCAN_CODE_SECOND = s_reg.scan;

   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (RST);

   sequence blocked_in_run;
      s_reg.main == ST_ON && !go_ok && !fault;
   endsequence

   sequence change_in_run;
      s_reg.main == ST_ON && chg;
   endsequence

   lock_outputs_off_a: assert property (s_reg.main == ST_LOCK |-> SAFETY_OUTPUT_PAIR == 2'b00)
      else $error("outputs on during lockout");
   lock_held_a: assert property (s_reg.main == ST_LOCK && !s_reg.rst_ok |=> s_reg.main == ST_LOCK)
      else $error("lockout left without reset");
   powerup_bank_a: assert property (s_reg.main == ST_POWERUP && pair_bad |=> LOCKOUT && ERROR_CODE != 8'h00)
      else $error("bank mismatch not locked out");
   cfg_change_a: assert property (change_in_run |=> s_reg.main == ST_LOCK ##1 LOCKOUT)
      else $error("switch change not locked out");
   scan_change_a: assert property (s_reg.main == ST_ON && !fault && go_ok && $changed(CFG_SW.scan_code_second) |=> !LOCKOUT)
      else $error("scan change caused lockout");
   trip_auto_on_a: assert property (s_reg.main == ST_OFF && !latch && go_ok && !fault |=> SAFETY_OUTPUT_PAIR == 2'b11)
      else $error("trip mode did not turn on");
   blocked_off_a: assert property (blocked_in_run |=> SAFETY_OUTPUT_PAIR == 2'b00)
      else $error("outputs stayed on when blocked");
   latch_needs_rst_a: assert property ($rose(SAFETY_OUTPUT_PAIR[0]) && latch |-> $past(s_reg.rst_ok))
      else $error("latch turned on without reset");
   reset_window_a: assert property (s_reg.rst_ok |-> $past(s_reg.cnt) >= MIN_C && $past(s_reg.cnt) <= MAX_C)
      else $error("reset accepted outside window");
   stuck_reset_a: assert property (s_reg.rd == RD_WAIT_OPEN && RESET_IN |=> !s_reg.rst_ok)
      else $error("closed input produced reset");
   aux_mirror_a: assert property (AUX_OUT == (SAFETY_OUTPUT_PAIR[0] && s_reg.snap.single_channel_monitor_setting))
      else $error("aux output wrong");
   coarse_both_a: assert property (COARSE_DETECTION_EN |-> s_reg.snap.coarse_a && s_reg.snap.coarse_b)
      else $error("coarse enabled by one switch");
   monitor_block_a: assert property (MONITOR_ERROR |-> !BLANKING_ALLOWED)
      else $error("blanking allowed with monitor error");

   // Closed inside the window, now seen open again
   sequence press_done;
      s_reg.rd == RD_CLOSED && !RESET_IN && s_reg.cnt >= MIN_C && s_reg.cnt <= MAX_C;
   endsequence

   press_accepted_a: assert property (press_done |=> s_reg.rst_ok)
      else $error("valid press not accepted");

   press_closed_a: assert property (s_reg.rst_ok |-> $past(s_reg.rd) == RD_CLOSED)
      else $error("reset without closed phase");

   sync_wait_a: assert property (s_reg.main == ST_SYNC && !SELF_TEST_OK && !fault
      |=> s_reg.main == ST_SYNC)
      else $error("left sync before self test");

   hold_off_a: assert property (s_reg.hold |=> SAFETY_OUTPUT_PAIR == 2'b00)
      else $error("outputs on during hold");

   code_match_a: assert property (s_reg.main == ST_OFF &&
      EMITTER_SCAN_CODE != CFG_SW.scan_code_second |=> SAFETY_OUTPUT_PAIR == 2'b00)
      else $error("outputs on with code mismatch");

   monitor_open_a: assert property (s_reg.main == ST_OFF && !mon_ok
      |=> SAFETY_OUTPUT_PAIR == 2'b00)
      else $error("outputs on with monitor open");

   lock_code_a: assert property (LOCKOUT |-> ERROR_CODE != 8'h00)
      else $error("lockout without error code");

   run_code_a: assert property (!LOCKOUT |-> ERROR_CODE == 8'h00)
      else $error("error code outside lockout");

   lock_exit_a: assert property (s_reg.main == ST_LOCK && s_reg.rst_ok && !pair_bad && !chg
      |=> !LOCKOUT)
      else $error("valid reset did not clear lockout");

   aux_single_a: assert property (!s_reg.snap.single_channel_monitor_setting
      |-> !AUX_OUT)
      else $error("aux output in dual mode");

   powerup_next_a: assert property (s_reg.main == ST_POWERUP
      |=> s_reg.main == ST_SYNC || s_reg.main == ST_LOCK)
      else $error("power-up check skipped");

   scan_follow_a: assert property (!$past(RST)
      |-> SCAN_CODE_SECOND == $past(CFG_SW.scan_code_second))
      else $error("scan code output stale");

   // Bus answer is a single registered pulse
   apb_ready_pulse_a: assert property (PREADY |=> !PREADY)
      else $error("ready held too long");

   apb_err_ready_a: assert property (PSLVERR |-> PREADY)
      else $error("error without ready");
endmodule
`default_nettype wire

// ===== slc_partner.sv
// Operator reset switch and machine monitor contacts
// Assumes the bench calls its tasks right after a rising clock edge
`default_nettype none
module slc_partner
(
   // Clock
   input wire logic CORE_CLK,
   // Switch and contacts
   output var logic RESET_IN,
   output var logic [1:0] EXTERNAL_DEVICE_MONITOR
);
   timeunit 1ns;
   timeprecision 100ps;
   initial
   begin
      // Switch left open, so trip mode must run without it
      RESET_IN = 1'h0;
      // Forced-guided contacts closed
      EXTERNAL_DEVICE_MONITOR = 2'h3;
   end
   // Operator closes for n cycles, then reopens
   task automatic press(input int n);
      RESET_IN <= 1'h1;
      repeat (n) @(posedge CORE_CLK);
      RESET_IN <= 1'h0;
      repeat (4) @(posedge CORE_CLK);
   endtask
   task automatic contacts(input logic [1:0] v);
      EXTERNAL_DEVICE_MONITOR <= v;
      repeat (2) @(posedge CORE_CLK);
   endtask
endmodule
`default_nettype wire

// ===== testbench.sv
// Self-checking bench for the curtain control block
// Assumes the partner model for reset switch and contacts
`default_nettype none
module testbench import slc_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;
   logic core_clk, rst, psel, penable, pwrite, pready, pslverr, re;
   logic [7:0] paddr, err_code;
   logic [31:0] pwdata, prdata, rd;
   slc_cfg_t cfg;
   logic reset_in, st_ok, beams, emit, aux, lock, mon_err, blank, coarse, scan;
   logic [1:0] external_device_monitor, safety_output_pair;
   int mismatches, n_checks;
   slc_curtain_ctrl #(.RST_MIN_CYC(8), .RST_MAX_CYC(40)) u_slc_curtain_ctrl (
      .CORE_CLK(core_clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready),
      .PRDATA(prdata), .PSLVERR(pslverr), .CFG_SW(cfg), .RESET_IN(reset_in),
      .SELF_TEST_OK(st_ok), .BEAMS_CLEAR(beams), .EMITTER_SCAN_CODE(emit),
      .EXTERNAL_DEVICE_MONITOR(external_device_monitor), .SAFETY_OUTPUT_PAIR(safety_output_pair), .AUX_OUT(aux),
      .LOCKOUT(lock), .ERROR_CODE(err_code), .MONITOR_ERROR(mon_err),
      .BLANKING_ALLOWED(blank), .COARSE_DETECTION_EN(coarse), .SCAN_CODE_SECOND(scan));
   slc_partner u_slc_partner (.CORE_CLK(core_clk), .RESET_IN(reset_in),
      .EXTERNAL_DEVICE_MONITOR(external_device_monitor));
   always #12.5 core_clk = ~core_clk;
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e)
      begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   // Setup, then access held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'h1;
      k = 0;
      do
      begin
         @(posedge core_clk);
         k++;
      end
      while (pready !== 1'h1 && k < 50);
      chk("pready", 1'h1, pready);
      rd = prdata;
      re = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge core_clk);
   endtask
   // Supply cycle modelled by the power-up reset
   task automatic power_up(input slc_cfg_t c);
      cfg <= c;
      rst <= 1'h1;
      cyc(2);
      rst <= 1'h0;
      cyc(8);
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial
   begin
      // Long enough for every press and power cycle below
      #(25 * 20000);
      mismatches++;
      wrap_up();
   end
   initial
   begin
      {core_clk, rst, psel, penable, pwrite, emit} = 6'h00;
      {paddr, pwdata, cfg} = '0;
      {st_ok, beams} = 2'h3;
      power_up(6'h00);
      chk("safety_output_pair", 2'h3, safety_output_pair);
      chk("aux", 1'h0, aux);
      chk("coarse", 1'h0, coarse);
      beams <= 1'h0;
      cyc(3);
      chk("safety_output_pair", 2'h0, safety_output_pair);
      beams <= 1'h1;
      st_ok <= 1'h0;
      cyc(3);
      chk("self_test", 2'h0, safety_output_pair);
      st_ok <= 1'h1;
      cfg <= 6'h20;
      emit <= 1'h1;
      cyc(3);
      chk("safety_output_pair", 2'h3, safety_output_pair);
      chk("scan", 1'h1, scan);
      emit <= 1'h0;
      cyc(3);
      chk("safety_output_pair", 2'h0, safety_output_pair);
      emit <= 1'h1;
      apb(1'h1, 8'h04, 32'h1);
      cyc(1);
      chk("hold", 2'h0, safety_output_pair);
      apb(1'h0, 8'h04, 32'h0);
      chk("ctrl", 32'h1, rd);
      apb(1'h1, 8'h04, 32'h0);
      apb(1'h0, 8'h08, 32'h0);
      chk("cfg", 32'h0, rd);
      apb(1'h0, 8'h10, 32'h0);
      chk("slverr", 1'h1, re);
      chk("safety_output_pair", 2'h3, safety_output_pair);
      u_slc_partner.contacts(2'h1);
      chk("mon_err", 1'h1, mon_err);
      chk("blank", 1'h0, blank);
      u_slc_partner.contacts(2'h3);
      cfg <= 6'h30;
      cyc(3);
      apb(1'h0, 8'h00, 32'h0);
      chk("status", 32'h9003, rd & 32'h79CFF);
      chk("safety_output_pair", 2'h0, safety_output_pair);
      cfg <= 6'h20;
      cyc(4);
      chk("lock", 1'h1, lock);
      u_slc_partner.press(20);
      cyc(2);
      chk("lock", 1'h0, lock);
      chk("safety_output_pair", 2'h3, safety_output_pair);
      power_up(6'h30);
      chk("err", 8'h2, err_code);
      chk("safety_output_pair", 2'h0, safety_output_pair);
      power_up(6'h24);
      chk("err", 8'h1, err_code);
      chk("lock", 1'h1, lock);
      power_up(6'h20);
      chk("lock", 1'h0, lock);
      power_up(6'h38);
      chk("safety_output_pair", 2'h0, safety_output_pair);
      u_slc_partner.press(7);
      chk("safety_output_pair", 2'h0, safety_output_pair);
      u_slc_partner.press(41);
      chk("safety_output_pair", 2'h0, safety_output_pair);
      u_slc_partner.press(120);
      chk("safety_output_pair", 2'h0, safety_output_pair);
      u_slc_partner.press(8);
      chk("safety_output_pair", 2'h3, safety_output_pair);
      beams <= 1'h0;
      cyc(3);
      beams <= 1'h1;
      cyc(4);
      chk("safety_output_pair", 2'h0, safety_output_pair);
      u_slc_partner.press(40);
      chk("safety_output_pair", 2'h3, safety_output_pair);
      power_up(6'h27);
      chk("coarse", 1'h1, coarse);
      chk("aux", 1'h1, aux);
      beams <= 1'h0;
      cyc(3);
      chk("aux", 1'h0, aux);
      wrap_up();
   end
endmodule
`default_nettype wire
